// ===== mccs_cfg.svh
// Offsets, field positions and reset values of the clock select register block.
// Assumes a 12-bit APB byte address with word-aligned registers.
`ifndef MCCS_CFG_SVH
`define MCCS_CFG_SVH

`define MCCS_OFS_MAIN_CLOCK_CONTROL 12'h000
`define MCCS_OFS_CPU_CLOCK_SELECT 12'h004
`define MCCS_OFS_HIGHSPEED_BUS_CLOCK_SELECT 12'h008
`define MCCS_OFS_PERIPH_BUS_A_CLOCK_SELECT 12'h00c
`define MCCS_OFS_PERIPH_BUS_B_CLOCK_SELECT 12'h010
`define MCCS_OFS_PROCESSOR_CLOCK_GATE 12'h020
`define MCCS_OFS_HIGHSPEED_BUS_CLOCK_GATE 12'h024
`define MCCS_OFS_PERIPH_BUS_A_CLOCK_GATE 12'h028
`define MCCS_OFS_PERIPH_BUS_B_CLOCK_GATE 12'h02c
`define MCCS_OFS_DIVIDED_CLOCK_GATE 12'h040
`define MCCS_OFS_CLOCK_FAILURE_CONTROL 12'h054
`define MCCS_OFS_WRITE_LOCK_KEY 12'h058
`define MCCS_OFS_IRQ_ENABLE_SET 12'h0c0
`define MCCS_OFS_IRQ_ENABLE_CLEAR 12'h0c4
`define MCCS_OFS_IRQ_ENABLED_VIEW 12'h0c8
`define MCCS_OFS_IRQ_PENDING 12'h0cc
`define MCCS_OFS_IRQ_PENDING_CLEAR 12'h0d0
`define MCCS_OFS_MANAGER_STATUS 12'h0d4
`define MCCS_OFS_PERIPHERAL_POWER_CONTROL 12'h160
`define MCCS_OFS_LAST_RESET_SOURCE 12'h180
`define MCCS_OFS_LAST_WAKE_SOURCE 12'h184
`define MCCS_OFS_ASYNC_WAKE_ENABLE 12'h188
`define MCCS_OFS_BUILD_CONFIGURATION 12'h3f8
`define MCCS_OFS_MODULE_REVISION 12'h3fc

`define MCCS_MAIN_SRC_MSB 2
`define MCCS_DIV_EN_BIT 7
`define MCCS_DIV_EXP_MSB 2
`define MCCS_STAT_FAIL_BIT 0
`define MCCS_STAT_RDY_BIT 5
`define MCCS_IRQ_IMPL 32'h00000021
`define MCCS_FAIL_EN_BIT 0
`define MCCS_FAIL_LOCK_BIT 31

`define MCCS_RST_PROCESSOR_CLOCK_GATE 32'h00010001
`define MCCS_RST_HIGHSPEED_BUS_CLOCK_GATE 32'h0000007f
`define MCCS_RST_PERIPH_BUS_A_CLOCK_GATE 32'h00ffffff
`define MCCS_RST_PERIPH_BUS_B_CLOCK_GATE 32'h0000000f
`define MCCS_RST_DIVIDED_CLOCK_GATE 7'h7f
`define MCCS_RST_PERIPHERAL_POWER_CONTROL 32'h000001fa
`define MCCS_RST_BUILD_CONFIGURATION 32'h00000043

`endif

// ===== mccs_clock_select.sv
// Main clock source select, CPU clock divider and power manager register file.
// Assumes an APB master on clk_sys, which also stands for the main clock here.
// What this block does
// - Decode source field into four oscillator choices.
// - Divide enable zero gives undivided CPU clock.
// - Divide enable one divides by two-power exponent+1.
// - CPU select write clears ready until applied.
// - Bus select register mirrors CPU select, read-only.
// - Source field low three bits, reset zero.
// - Peripheral power control resets to 0x1fa.
// - Wake enable register resets to zero.
// - Failure detector control resets to zero.
// - Ready rises when new selects take effect.
// - Pending bit sets on rise, clears by write.
// - Enable/disable masks; interrupt is masked OR.
// - Failure forces source field to system oscillator.
`include "mccs_cfg.svh"

module mccs_clock_select #(
    parameter logic [31:0] MODULE_REVISION = 32'h00000100 // Arbitrary value.
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire mccs_pkg::mccs_apb_req_t apb_req,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic main_clock_failed,
    input wire logic [31:0] last_reset_source,
    input wire logic [31:0] last_wake_source,
    output logic [2:0] main_source_field,
    output logic [3:0] main_source_onehot,
    output logic cpu_clk_tick,
    output logic clock_settings_ready,
    output logic clock_failure_detect_enable,
    output logic irq
);

    mccs_pkg::mccs_state_t s;
    mccs_pkg::mccs_state_t next_s;

    function automatic logic [3:0] decode_src(input logic [2:0] f);
        unique case (f)
            mccs_pkg::MCCS_SRC_SYSTEM_RC_OSC: decode_src = 4'h1;
            mccs_pkg::MCCS_SRC_CRYSTAL_OSC_ZERO: decode_src = 4'h2;
            mccs_pkg::MCCS_SRC_DIGITAL_FREQ_LOCKED_LOOP: decode_src = 4'h4;
            mccs_pkg::MCCS_SRC_FAST_RC_OSC: decode_src = 4'h8;
            default: decode_src = 4'h0;
        endcase
    endfunction

    // Expands a stored {divide enable, exponent} pair into its register image.
    function automatic logic [31:0] sel_image(input logic [3:0] v);
        sel_image = {24'h000000, v[3], 4'h0, v[2:0]};
    endfunction

    function automatic logic [3:0] sel_field(input logic [31:0] d);
        sel_field = {d[`MCCS_DIV_EN_BIT], d[`MCCS_DIV_EXP_MSB:0]};
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        if (a[1:0] != 2'b00) begin
            is_mapped = 1'b0;
        end else begin
            unique case (a)
                `MCCS_OFS_MAIN_CLOCK_CONTROL, `MCCS_OFS_CPU_CLOCK_SELECT,
                `MCCS_OFS_HIGHSPEED_BUS_CLOCK_SELECT, `MCCS_OFS_PERIPH_BUS_A_CLOCK_SELECT,
                `MCCS_OFS_PERIPH_BUS_B_CLOCK_SELECT, `MCCS_OFS_PROCESSOR_CLOCK_GATE,
                `MCCS_OFS_HIGHSPEED_BUS_CLOCK_GATE, `MCCS_OFS_PERIPH_BUS_A_CLOCK_GATE,
                `MCCS_OFS_PERIPH_BUS_B_CLOCK_GATE, `MCCS_OFS_DIVIDED_CLOCK_GATE,
                `MCCS_OFS_CLOCK_FAILURE_CONTROL, `MCCS_OFS_WRITE_LOCK_KEY,
                `MCCS_OFS_IRQ_ENABLE_SET, `MCCS_OFS_IRQ_ENABLE_CLEAR,
                `MCCS_OFS_IRQ_ENABLED_VIEW, `MCCS_OFS_IRQ_PENDING,
                `MCCS_OFS_IRQ_PENDING_CLEAR, `MCCS_OFS_MANAGER_STATUS,
                `MCCS_OFS_PERIPHERAL_POWER_CONTROL, `MCCS_OFS_LAST_RESET_SOURCE,
                `MCCS_OFS_LAST_WAKE_SOURCE, `MCCS_OFS_ASYNC_WAKE_ENABLE,
                `MCCS_OFS_BUILD_CONFIGURATION, `MCCS_OFS_MODULE_REVISION: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    logic [31:0] status_now;
    logic [31:0] rd_mux;
    logic wr_acc;
    logic rd_setup;
    logic [8:0] period;
    logic [7:0] period_m1;
    logic wrap;

    assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign pready = 1'b1;
    assign pslverr = apb_req.psel & apb_req.penable & ~is_mapped(apb_req.paddr);

    always_comb begin
        status_now = 32'h00000000;
        status_now[`MCCS_STAT_FAIL_BIT] = s.fail_flag;
        status_now[`MCCS_STAT_RDY_BIT] = s.clock_settings_ready;
    end

    // Write-only and reserved locations read as zero.
    always_comb begin
        rd_mux = 32'h00000000;
        if (is_mapped(apb_req.paddr)) begin
            unique case (apb_req.paddr)
                `MCCS_OFS_MAIN_CLOCK_CONTROL: rd_mux = {29'h0, s.main_source_field};
                `MCCS_OFS_CPU_CLOCK_SELECT: rd_mux = sel_image(s.cpu_sel);
                `MCCS_OFS_HIGHSPEED_BUS_CLOCK_SELECT: rd_mux = sel_image(s.cpu_sel);
                `MCCS_OFS_PERIPH_BUS_A_CLOCK_SELECT: rd_mux = sel_image(s.pba_sel);
                `MCCS_OFS_PERIPH_BUS_B_CLOCK_SELECT: rd_mux = sel_image(s.pbb_sel);
                `MCCS_OFS_PROCESSOR_CLOCK_GATE: rd_mux = s.processor_clock_gate;
                `MCCS_OFS_HIGHSPEED_BUS_CLOCK_GATE: rd_mux = s.highspeed_bus_clock_gate;
                `MCCS_OFS_PERIPH_BUS_A_CLOCK_GATE: rd_mux = s.periph_bus_a_clock_gate;
                `MCCS_OFS_PERIPH_BUS_B_CLOCK_GATE: rd_mux = s.periph_bus_b_clock_gate;
                `MCCS_OFS_DIVIDED_CLOCK_GATE: rd_mux = {25'h0, s.divided_clock_gate};
                `MCCS_OFS_CLOCK_FAILURE_CONTROL: rd_mux = {s.fail_lock, 30'h0, s.fail_en};
                `MCCS_OFS_IRQ_ENABLED_VIEW: rd_mux = s.irq_enabled_view;
                `MCCS_OFS_IRQ_PENDING: rd_mux = s.irq_pending;
                `MCCS_OFS_MANAGER_STATUS: rd_mux = status_now;
                `MCCS_OFS_PERIPHERAL_POWER_CONTROL: rd_mux = s.peripheral_power_control;
                `MCCS_OFS_LAST_RESET_SOURCE: rd_mux = last_reset_source;
                `MCCS_OFS_LAST_WAKE_SOURCE: rd_mux = last_wake_source;
                `MCCS_OFS_ASYNC_WAKE_ENABLE: rd_mux = s.async_wake_enable;
                `MCCS_OFS_BUILD_CONFIGURATION: rd_mux = `MCCS_RST_BUILD_CONFIGURATION;
                `MCCS_OFS_MODULE_REVISION: rd_mux = MODULE_REVISION;
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // The divider runs off the applied setting, never the freshly written one.
    always_comb begin
        period = 9'h002 << s.cpu_active[2:0];
        period_m1 = s.cpu_active[3] ? 8'(period - 9'h001) : 8'h00;
        wrap = (s.div_cnt >= period_m1);
    end

    always_comb begin
        next_s = s;
        next_s.cpu_clk_tick = wrap;
        next_s.div_cnt = wrap ? 8'h00 : 8'(s.div_cnt + 8'h01);
        // A new select is applied only at a period boundary to avoid a short pulse.
        if (s.pending && wrap) begin
            next_s.cpu_active = s.cpu_sel;
            next_s.pending = 1'b0;
            next_s.clock_settings_ready = 1'b1;
        end
        if (rd_setup) begin
            next_s.prdata = rd_mux;
        end
        if (wr_acc) begin
            unique case (apb_req.paddr)
                `MCCS_OFS_MAIN_CLOCK_CONTROL: begin
                    next_s.main_source_field = apb_req.pwdata[`MCCS_MAIN_SRC_MSB:0];
                    next_s.fail_flag = 1'b0;
                end
                `MCCS_OFS_CPU_CLOCK_SELECT: begin
                    next_s.cpu_sel = sel_field(apb_req.pwdata);
                    next_s.pending = 1'b1;
                    next_s.clock_settings_ready = 1'b0;
                end
                `MCCS_OFS_PERIPH_BUS_A_CLOCK_SELECT: begin
                    next_s.pba_sel = sel_field(apb_req.pwdata);
                    next_s.pending = 1'b1;
                    next_s.clock_settings_ready = 1'b0;
                end
                `MCCS_OFS_PERIPH_BUS_B_CLOCK_SELECT: begin
                    next_s.pbb_sel = sel_field(apb_req.pwdata);
                    next_s.pending = 1'b1;
                    next_s.clock_settings_ready = 1'b0;
                end
                `MCCS_OFS_PROCESSOR_CLOCK_GATE: next_s.processor_clock_gate = apb_req.pwdata;
                `MCCS_OFS_HIGHSPEED_BUS_CLOCK_GATE: begin
                    next_s.highspeed_bus_clock_gate = apb_req.pwdata;
                end
                `MCCS_OFS_PERIPH_BUS_A_CLOCK_GATE: next_s.periph_bus_a_clock_gate = apb_req.pwdata;
                `MCCS_OFS_PERIPH_BUS_B_CLOCK_GATE: next_s.periph_bus_b_clock_gate = apb_req.pwdata;
                `MCCS_OFS_DIVIDED_CLOCK_GATE: next_s.divided_clock_gate = apb_req.pwdata[6:0];
                `MCCS_OFS_CLOCK_FAILURE_CONTROL: begin
                    // Once the store-final bit is set the register is frozen.
                    if (!s.fail_lock) begin
                        next_s.fail_en = apb_req.pwdata[`MCCS_FAIL_EN_BIT];
                        next_s.fail_lock = apb_req.pwdata[`MCCS_FAIL_LOCK_BIT];
                    end
                end
                `MCCS_OFS_IRQ_ENABLE_SET: begin
                    next_s.irq_enabled_view = s.irq_enabled_view
                        | (apb_req.pwdata & `MCCS_IRQ_IMPL);
                end
                `MCCS_OFS_IRQ_ENABLE_CLEAR: begin
                    next_s.irq_enabled_view = s.irq_enabled_view & ~apb_req.pwdata;
                end
                `MCCS_OFS_PERIPHERAL_POWER_CONTROL: begin
                    next_s.peripheral_power_control = apb_req.pwdata;
                end
                `MCCS_OFS_ASYNC_WAKE_ENABLE: next_s.async_wake_enable = apb_req.pwdata;
                default: begin
                end
            endcase
        end
        // A failure overrides a simultaneous software write of the source field unless the field already holds the system oscillator.
        if (s.fail_en && main_clock_failed
                && (s.main_source_field != mccs_pkg::MCCS_SRC_SYSTEM_RC_OSC)) begin
            next_s.main_source_field = mccs_pkg::MCCS_SRC_SYSTEM_RC_OSC;
            next_s.fail_flag = 1'b1;
        end
        next_s.src_onehot = decode_src(next_s.main_source_field);
        // A rising status bit sets its pending bit even in a clearing cycle.
        next_s.stat_prev = status_now;
        next_s.irq_pending = s.irq_pending;
        if (wr_acc && (apb_req.paddr == `MCCS_OFS_IRQ_PENDING_CLEAR)) begin
            next_s.irq_pending = s.irq_pending & ~apb_req.pwdata;
        end
        next_s.irq_pending = next_s.irq_pending | (status_now & ~s.stat_prev);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.src_onehot <= 4'h1;
            s.cpu_clk_tick <= 1'b1;
            s.clock_settings_ready <= 1'b1;
            s.stat_prev <= 32'h00000020;
            s.processor_clock_gate <= `MCCS_RST_PROCESSOR_CLOCK_GATE;
            s.highspeed_bus_clock_gate <= `MCCS_RST_HIGHSPEED_BUS_CLOCK_GATE;
            s.periph_bus_a_clock_gate <= `MCCS_RST_PERIPH_BUS_A_CLOCK_GATE;
            s.periph_bus_b_clock_gate <= `MCCS_RST_PERIPH_BUS_B_CLOCK_GATE;
            s.divided_clock_gate <= `MCCS_RST_DIVIDED_CLOCK_GATE;
            s.peripheral_power_control <= `MCCS_RST_PERIPHERAL_POWER_CONTROL;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign main_source_field = s.main_source_field;
    assign main_source_onehot = s.src_onehot;
    assign cpu_clk_tick = s.cpu_clk_tick;
    assign clock_settings_ready = s.clock_settings_ready;
    assign clock_failure_detect_enable = s.fail_en;
    assign irq = |(s.irq_pending & s.irq_enabled_view);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_src_decode;
        main_source_field == 3'h3 |-> main_source_onehot == 4'h8;
    endproperty
    a_src_decode: assert property (p_src_decode) else $error("Source decode wrong.");

    property p_undivided;
        !s.cpu_active[3] |=> cpu_clk_tick;
    endproperty
    a_undivided: assert property (p_undivided) else $error("Undivided tick missing.");

    property p_div_two;
        s.cpu_active == 4'h8 && !s.pending && cpu_clk_tick |=> !cpu_clk_tick ##1 cpu_clk_tick;
    endproperty
    a_div_two: assert property (p_div_two) else $error("Divide by two wrong.");

    property p_wr_clears_ready;
        wr_acc && apb_req.paddr == `MCCS_OFS_CPU_CLOCK_SELECT |=> !clock_settings_ready;
    endproperty
    a_wr_clears_ready: assert property (p_wr_clears_ready)
        else $error("Ready not cleared by write.");

    property p_mirror;
        rd_setup && apb_req.paddr == `MCCS_OFS_HIGHSPEED_BUS_CLOCK_SELECT
            |=> prdata == sel_image($past(s.cpu_sel));
    endproperty
    a_mirror: assert property (p_mirror) else $error("Mirror differs.");

    property p_power_hold;
        !(wr_acc && apb_req.paddr == `MCCS_OFS_PERIPHERAL_POWER_CONTROL)
            |=> $stable(s.peripheral_power_control);
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("Power control changed.");

    property p_wake_hold;
        !(wr_acc && apb_req.paddr == `MCCS_OFS_ASYNC_WAKE_ENABLE) |=> $stable(s.async_wake_enable);
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("Wake enable changed.");

    property p_fail_frozen;
        s.fail_lock |=> s.fail_lock && $stable(s.fail_en);
    endproperty
    a_fail_frozen: assert property (p_fail_frozen) else $error("Frozen control moved.");

    property p_ready_pends;
        $rose(clock_settings_ready) |=> s.irq_pending[`MCCS_STAT_RDY_BIT];
    endproperty
    a_ready_pends: assert property (p_ready_pends) else $error("Ready edge lost.");

    property p_irq_or;
        irq == |(s.irq_pending & s.irq_enabled_view);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("Interrupt mismatch.");

    // The pending bit follows the status flag one cycle later.
    property p_failover;
        s.fail_en && main_clock_failed && main_source_field != 3'h0
            |=> main_source_field == 3'h0 && s.fail_flag
            ##1 s.irq_pending[`MCCS_STAT_FAIL_BIT];
    endproperty
    a_failover: assert property (p_failover) else $error("Failover missing.");

    property p_unmapped;
        rd_setup && !is_mapped(apb_req.paddr) |=> prdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read nonzero.");

    property p_src_sys;
        main_source_field == 3'h0 |-> main_source_onehot == 4'h1;
    endproperty
    a_src_sys: assert property (p_src_sys) else $error("System source decode wrong.");

    property p_src_xtal;
        main_source_field == 3'h1 |-> main_source_onehot == 4'h2;
    endproperty
    a_src_xtal: assert property (p_src_xtal) else $error("Crystal decode wrong.");

    property p_src_loop;
        main_source_field == 3'h2 |-> main_source_onehot == 4'h4;
    endproperty
    a_src_loop: assert property (p_src_loop) else $error("Locked loop decode wrong.");

    property p_src_unused;
        main_source_field[2] |-> main_source_onehot == 4'h0;
    endproperty
    a_src_unused: assert property (p_src_unused) else $error("Unused code selects.");

    property p_div_four;
        s.cpu_active == 4'h9 && !s.pending && cpu_clk_tick
            |=> !cpu_clk_tick [*3] ##1 cpu_clk_tick;
    endproperty
    a_div_four: assert property (p_div_four) else $error("Divide by four wrong.");

    // Only a select write may take the ready flag down.
    property p_ready_held;
        clock_settings_ready && !(wr_acc && (apb_req.paddr == `MCCS_OFS_CPU_CLOCK_SELECT
            || apb_req.paddr == `MCCS_OFS_PERIPH_BUS_A_CLOCK_SELECT
            || apb_req.paddr == `MCCS_OFS_PERIPH_BUS_B_CLOCK_SELECT)) |=> clock_settings_ready;
    endproperty
    a_ready_held: assert property (p_ready_held) else $error("Ready dropped.");

    property p_enable_set;
        wr_acc && apb_req.paddr == `MCCS_OFS_IRQ_ENABLE_SET
            && apb_req.pwdata[`MCCS_STAT_RDY_BIT] |=> s.irq_enabled_view[`MCCS_STAT_RDY_BIT];
    endproperty
    a_enable_set: assert property (p_enable_set) else $error("Enable not set.");

    property p_enable_clear;
        wr_acc && apb_req.paddr == `MCCS_OFS_IRQ_ENABLE_CLEAR
            && apb_req.pwdata[`MCCS_STAT_RDY_BIT] |=> !s.irq_enabled_view[`MCCS_STAT_RDY_BIT];
    endproperty
    a_enable_clear: assert property (p_enable_clear) else $error("Enable not cleared.");

    // A clear that meets a fresh rising edge loses, so that case is left out.
    property p_pend_clear;
        wr_acc && apb_req.paddr == `MCCS_OFS_IRQ_PENDING_CLEAR
            && apb_req.pwdata[`MCCS_STAT_FAIL_BIT]
            && !(status_now[`MCCS_STAT_FAIL_BIT] && !s.stat_prev[`MCCS_STAT_FAIL_BIT])
            |=> !s.irq_pending[`MCCS_STAT_FAIL_BIT];
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("Pending bit not cleared.");

    property p_source_upper_zero;
        rd_setup && apb_req.paddr == `MCCS_OFS_MAIN_CLOCK_CONTROL |=> prdata[31:3] == 29'h0;
    endproperty
    a_source_upper_zero: assert property (p_source_upper_zero)
        else $error("Unused source bits read.");

    c_cpu_write: cover property (wr_acc && apb_req.paddr == `MCCS_OFS_CPU_CLOCK_SELECT
        ##[1:300] $rose(clock_settings_ready));
    c_failover: cover property ($rose(s.fail_flag));
    c_irq: cover property ($rose(irq));
    c_fast_src: cover property (main_source_field == 3'h3);
    c_lock: cover property ($rose(s.fail_lock));

endmodule

// ===== mccs_clock_select_tb_top.sv
// Self-checking testbench for the clock select register block.
// Assumes mccs_pkg is compiled first and the assertions sit in the design itself.
module mccs_clock_select_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_sys;
    logic rst_n;
    mccs_pkg::mccs_apb_req_t req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic main_clock_failed;
    logic [2:0] src;
    logic [3:0] onehot;
    logic tick;
    logic ready;
    logic det_en;
    logic last_err;
    logic irq;
    int failures;
    int num_checks;
    int p;
    logic [11:0] ra [18] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h020,
        12'h024, 12'h028, 12'h02c, 12'h040, 12'h054, 12'h0c8, 12'h0cc, 12'h0d4, 12'h160,
        12'h188, 12'h3f8};
    logic [31:0] rv [18] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00010001, 32'h7f,
        32'h00ffffff, 32'hf, 32'h7f, 32'h0, 32'h0, 32'h0, 32'h20, 32'h1fa, 32'h0, 32'h43};

    mccs_clock_select dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .apb_req(req),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .main_clock_failed(main_clock_failed),
        .last_reset_source(32'h5),
        .last_wake_source(32'h9),
        .main_source_field(src),
        .main_source_onehot(onehot),
        .cpu_clk_tick(tick),
        .clock_settings_ready(ready),
        .clock_failure_detect_enable(det_en),
        .irq(irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task close_out;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at a rising edge.
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge clk_sys);
        req.penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 50) chk(32'h0, 32'h1, "no pready");
        q = prdata;
        last_err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(a, 1'b1, d, q);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(a, 1'b0, 32'h0, q);
        chk(q, exp, "read data");
    endtask

    task wait_ready;
        int n;
        n = 0;
        @(negedge clk_sys);
        while (ready !== 1'b1 && n < 600) begin
            n++;
            @(negedge clk_sys);
        end
        chk({31'h0, ready}, 32'h1, "ready return");
    endtask

    // Cycles between two successive CPU clock ticks.
    task period(output int cnt);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (tick !== 1'b1 && n < 50) begin
            n++;
            @(negedge clk_sys);
        end
        cnt = 0;
        do begin
            @(negedge clk_sys);
            cnt++;
        end while (tick !== 1'b1 && cnt < 50);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        close_out();
    end

    initial begin
        failures = 0;
        num_checks = 0;
        req = '0;
        main_clock_failed = 1'b0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 18; i++) rd(ra[i], rv[i]);
        rd(12'h180, 32'h5);
        rd(12'h184, 32'h9);
        // Divider exponents 0..2 with division on; the last leaves the CPU at main/8.
        for (int e = 0; e < 3; e++) begin
            wr(12'h004, 32'h80 | 32'(e));
            @(negedge clk_sys);
            chk({31'h0, ready}, 32'h0, "ready after write");
            wait_ready();
            period(p);
            chk(32'(p), 32'h1 << (e + 1), "tick period");
            rd(12'h008, 32'h80 | 32'(e));
        end
        rd(12'h0cc, 32'h20);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(12'h0c0, 32'h20);
        rd(12'h0c8, 32'h20);
        @(negedge clk_sys);
        chk({31'h0, irq}, 32'h1, "irq enabled");
        wr(12'h0c4, 32'h20);
        rd(12'h0c8, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq disabled");
        wr(12'h0c0, 32'h21);
        wr(12'h0d0, 32'h20);
        rd(12'h0cc, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        for (int s = 0; s < 4; s++) begin
            wr(12'h000, 32'(s));
            @(negedge clk_sys);
            chk({28'h0, onehot}, 32'h1 << s, "source decode");
            rd(12'h000, 32'(s));
        end
        wr(12'h000, 32'hffffffff);
        rd(12'h000, 32'h7);
        chk({28'h0, onehot}, 32'h0, "unused code");
        wr(12'h000, 32'h1);
        wr(12'h054, 32'h1);
        @(negedge clk_sys);
        chk({31'h0, det_en}, 32'h1, "detector enable");
        @(posedge clk_sys);
        main_clock_failed <= 1'b1;
        repeat (3) @(posedge clk_sys);
        main_clock_failed <= 1'b0;
        @(negedge clk_sys);
        chk({29'h0, src}, 32'h0, "failure fallback");
        chk({31'h0, irq}, 32'h1, "failure irq");
        rd(12'h000, 32'h0);
        rd(12'h0d4, 32'h21);
        rd(12'h0cc, 32'h1);
        wr(12'h0d0, 32'h1);
        @(negedge clk_sys);
        chk({31'h0, irq}, 32'h0, "failure irq cleared");
        wr(12'h054, 32'h80000001);
        wr(12'h054, 32'h0);
        rd(12'h054, 32'h80000001);
        wr(12'h160, 32'h5a5a5a5a);
        rd(12'h160, 32'h5a5a5a5a);
        chk({31'h0, last_err}, 32'h0, "mapped error");
        wr(12'h188, 32'ha5a5a5a5);
        rd(12'h188, 32'ha5a5a5a5);
        wr(12'h014, 32'hffffffff);
        rd(12'h014, 32'h0);
        chk({31'h0, last_err}, 32'h1, "reserved error");
        wr(12'h008, 32'h0);
        rd(12'h008, 32'h82);
        wr(12'h00c, 32'h81);
        @(negedge clk_sys);
        chk({31'h0, ready}, 32'h0, "ready after bus write");
        wait_ready();
        rd(12'h00c, 32'h81);
        wr(12'h004, 32'h0);
        wait_ready();
        period(p);
        chk(32'(p), 32'h1, "undivided period");
        rd(12'h008, 32'h0);
        close_out();
    end
endmodule

// ===== mccs_pkg.sv
// Types shared by the clock select register block.
// Assumes mccs_cfg.svh supplies the numeric constants.
package mccs_pkg;

    typedef enum logic [2:0] {
        MCCS_SRC_SYSTEM_RC_OSC = 3'b000,
        MCCS_SRC_CRYSTAL_OSC_ZERO = 3'b001,
        MCCS_SRC_DIGITAL_FREQ_LOCKED_LOOP = 3'b010,
        MCCS_SRC_FAST_RC_OSC = 3'b011
    } mccs_src_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
        logic psel;
        logic penable;
    } mccs_apb_req_t;

    typedef struct packed {
        logic [2:0] main_source_field;
        logic [3:0] src_onehot;
        logic [3:0] cpu_sel;
        logic [3:0] pba_sel;
        logic [3:0] pbb_sel;
        logic [3:0] cpu_active;
        logic [7:0] div_cnt;
        logic cpu_clk_tick;
        logic pending;
        logic clock_settings_ready;
        logic fail_flag;
        logic [31:0] processor_clock_gate;
        logic [31:0] highspeed_bus_clock_gate;
        logic [31:0] periph_bus_a_clock_gate;
        logic [31:0] periph_bus_b_clock_gate;
        logic [6:0] divided_clock_gate;
        logic fail_en;
        logic fail_lock;
        logic [31:0] peripheral_power_control;
        logic [31:0] async_wake_enable;
        logic [31:0] irq_enabled_view;
        logic [31:0] irq_pending;
        logic [31:0] stat_prev;
        logic [31:0] prdata;
    } mccs_state_t;

endpackage
